// file: src/msds_pkg.sv
// constants, types and register map of the serial dma start-up block
// What this block does
// - action request builds queues, then sets acknowledge
// - interrupt enabled: raise output, store config vector
// - ready channel draws transmit fifo, sends data
// - channel events forwarded as vectors to memory
// - multifunction port: local bus, general, serial
// - receive fifo moved to memory at threshold
package msds_pkg;
   localparam logic [7:0]  GCMD_OFF   = 8'h00;
   localparam logic [7:0]  GSTAT_OFF  = 8'h04;
   localparam logic [7:0]  GLOBAL_MODE_REG_OFF  = 8'h08;
   localparam logic [7:0]  CC0_OFF    = 8'h0C;
   localparam logic [7:0]  CC2_OFF    = 8'h10;
   localparam logic [7:0]  IMR_OFF    = 8'h14;
   localparam logic [7:0]  QBASE_OFF  = 8'h18;
   localparam logic [7:0]  RXBASE_OFF = 8'h1C;
   localparam logic [7:0]  RXTHR_OFF  = 8'h20;
   localparam logic [7:0]  TXD_OFF    = 8'h24;
   // global_command_reg bits
   localparam int AR_BIT     = 0;
   localparam int QINIT_BIT  = 1;
   localparam int RXDMA_BIT  = 2;
   localparam int TXDMA_BIT  = 3;
   // global_status_reg bits
   localparam int ACK_BIT    = 0;
   localparam int CFGI_BIT   = 1;
   localparam int RXI_BIT    = 2;
   localparam int TXI_BIT    = 3;
   localparam int BUSY_BIT   = 4;
   localparam int LVL_LSB    = 8;
   // global_mode_reg, chan_control_0, chan_control_2 bits
   localparam int IRQEN_BIT  = 2;
   localparam int PU_BIT     = 0;
   localparam int TXRES_BIT  = 1;
   localparam int RAC_BIT    = 0;
   localparam logic [2:0]  MODE_RST   = 3'h0;
   localparam logic [1:0]  IMR_RST    = 2'h3;
   localparam logic [4:0]  THR_RST    = 5'h08;
   localparam logic [31:0] ADDR_RST   = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   localparam int          FIFO_DEPTH = 16;
   localparam int          EVQ_LEN    = 4;
   localparam logic [31:0] EVQ_OFF    = 32'h0000_0040;
   localparam logic [31:0] VEC_CFG    = 32'h0000_0C01;
   localparam logic [31:0] VEC_RX     = 32'h0000_0A01;
   localparam logic [31:0] VEC_TX     = 32'h0000_0A02;
   localparam logic [1:0]  PCFG_LBI   = 2'h0;
   localparam logic [1:0]  PCFG_SSC   = 2'h2;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
   } msds_mem_req_s;

   typedef struct packed {
      logic local_bus_en;
      logic gp_port_en;
      logic sync_serial_en;
   } msds_mfp_s;

   typedef enum logic [2:0] {CTL_IDLE, CTL_QINIT, CTL_DONE, CTL_CFGVEC, CTL_RXMOVE} msds_ctl_e;
endpackage : msds_pkg

// file: src/msds_fifo.sv
// fifo with registered read data, used for the central transmit and receive fifos
`timescale 1ns/100ps
module msds_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr_r, wptr_nxt, rptr_r, rptr_nxt;
   logic [CW-1:0]    cnt_r, cnt_nxt;
   logic             ov_r, ov_nxt;
   logic [WIDTH-1:0] od_r, od_nxt;
   logic             push, load;

   // output stage counts toward depth so full really means DEPTH words held
   assign level     = cnt_r + CW'(ov_r);
   assign in_ready  = level < CW'(DEPTH);
   assign out_valid = ov_r;
   assign out_data  = od_r;

   always_comb begin
      push     = in_valid && in_ready;
      load     = (cnt_r != '0) && (!ov_r || out_ready);
      wptr_nxt = push ? wptr_r + AW'(1) : wptr_r;
      rptr_nxt = load ? rptr_r + AW'(1) : rptr_r;
      cnt_nxt  = cnt_r + CW'(push) - CW'(load);
      ov_nxt   = load ? 1'b1 : ((ov_r && out_ready) ? 1'b0 : ov_r);
      od_nxt   = load ? mem[rptr_r] : od_r;
   end

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wptr_r] <= in_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r  <= '0;
         ov_r   <= 1'b0;
         od_r   <= '0;
      end else begin
         wptr_r <= wptr_nxt;
         rptr_r <= rptr_nxt;
         cnt_r  <= cnt_nxt;
         ov_r   <= ov_nxt;
         od_r   <= od_nxt;
      end
   end
endmodule : msds_fifo

// file: src/msds_top.sv
// start-up sequencer, dma mover and register file of the serial dma block
`timescale 1ns/100ps
module msds_top (
   input  wire logic                   ref_clk,
   input  wire logic                   rst,
   input  wire logic [7:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [7:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   output logic                        mem_wr_valid,
   input  wire logic                   mem_wr_ready,
   output msds_pkg::msds_mem_req_s     mem_wr,
   output logic                        ser_tx_valid,
   input  wire logic                   ser_tx_ready,
   output logic [31:0]                 ser_tx_data,
   input  wire logic                   ser_rx_valid,
   output logic                        ser_rx_ready,
   input  wire logic [31:0]            ser_rx_data,
   input  wire logic                   chan_rx_event,
   input  wire logic                   chan_tx_event,
   output logic                        irq_out,
   output msds_pkg::msds_mfp_s         port_sel
);
   logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
   logic [7:0]  waddr_r, waddr_nxt;
   logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, rd_val;
   logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt, rd_ok, wr_ok, wr_go;
   logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic        ar_pend_r, ar_pend_nxt, qinit_r, qinit_nxt;
   logic        rxd_en_r, rxd_en_nxt, txd_en_r, txd_en_nxt;
   logic [2:0]  mode_r, mode_nxt;
   logic        power_up_r, power_up_nxt, tx_rst_done_r, tx_rst_done_nxt;
   logic        rx_active_r, rx_active_nxt;
   logic [1:0]  imr_r, imr_nxt;
   logic [31:0] qbase_r, qbase_nxt, rxbase_r, rxbase_nxt;
   logic [4:0]  rx_thr_r, rx_thr_nxt, cnt_r, cnt_nxt;
   logic [3:0]  stat_r, stat_nxt, stat_set;
   logic        rx_pend_r, rx_pend_nxt, tx_pend_r, tx_pend_nxt;
   logic [1:0]  evptr_r, evptr_nxt;
   logic [7:0]  rxptr_r, rxptr_nxt;
   logic        mreq_valid_r, mreq_valid_nxt, mem_free, irq_r, irq_nxt;
   msds_pkg::msds_mem_req_s mreq_r, mreq_nxt;
   msds_pkg::msds_mfp_s     port_r, port_nxt;
   msds_pkg::msds_ctl_e     ctl_r, ctl_nxt;
   logic        txf_in_valid, txf_in_ready, txf_out_valid, txf_out_ready, tx_on;
   logic        rxf_in_valid, rxf_in_ready, rxf_out_valid, rxf_out_ready;
   logic [31:0] txf_out_data, rxf_out_data;
   logic [4:0]  txf_level, rxf_level;

   assign s_axi_awready = !aw_hold_r && !bvalid_r;
   assign s_axi_wready  = !w_hold_r && !bvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign mem_wr_valid  = mreq_valid_r;
   assign mem_wr        = mreq_r;
   assign irq_out       = irq_r;
   assign port_sel      = port_r;
   // transmit data only once powered, transmitter reset and dma enabled
   assign tx_on         = power_up_r && tx_rst_done_r && txd_en_r;
   assign ser_tx_valid  = txf_out_valid && tx_on;
   assign txf_out_ready = ser_tx_ready && tx_on;
   assign ser_tx_data   = txf_out_data;
   assign rxf_in_valid  = ser_rx_valid && rx_active_r;
   assign ser_rx_ready  = rxf_in_ready && rx_active_r;
   // a data write stalls its response until the transmit fifo has room
   assign txf_in_valid  = aw_hold_r && w_hold_r && !bvalid_r && (waddr_r == msds_pkg::TXD_OFF);
   assign mem_free      = !mreq_valid_r || mem_wr_ready;

   msds_fifo #(.WIDTH(32), .DEPTH(msds_pkg::FIFO_DEPTH)) u_tx_fifo (
      .ref_clk(ref_clk), .rst(rst),
      .in_valid(txf_in_valid), .in_ready(txf_in_ready), .in_data(wdata_r),
      .out_valid(txf_out_valid), .out_ready(txf_out_ready), .out_data(txf_out_data),
      .level(txf_level)
   );

   msds_fifo #(.WIDTH(32), .DEPTH(msds_pkg::FIFO_DEPTH)) u_rx_fifo (
      .ref_clk(ref_clk), .rst(rst),
      .in_valid(rxf_in_valid), .in_ready(rxf_in_ready), .in_data(ser_rx_data),
      .out_valid(rxf_out_valid), .out_ready(rxf_out_ready), .out_data(rxf_out_data),
      .level(rxf_level)
   );

   always_comb begin
      rd_ok = 1'b1;
      rd_val = '0;
      case ({s_axi_araddr[7:2], 2'b00})
         msds_pkg::GCMD_OFF: begin
            rd_val[msds_pkg::QINIT_BIT] = qinit_r;
            rd_val[msds_pkg::RXDMA_BIT] = rxd_en_r;
            rd_val[msds_pkg::TXDMA_BIT] = txd_en_r;
         end
         msds_pkg::GSTAT_OFF: begin
            rd_val[3:0] = stat_r;
            rd_val[msds_pkg::BUSY_BIT] = ar_pend_r || (ctl_r != msds_pkg::CTL_IDLE);
            rd_val[msds_pkg::LVL_LSB +: 5] = rxf_level;
            rd_val[msds_pkg::LVL_LSB+8 +: 5] = txf_level;
         end
         msds_pkg::GLOBAL_MODE_REG_OFF:  rd_val[2:0] = mode_r;
         msds_pkg::CC0_OFF: begin
            rd_val[msds_pkg::PU_BIT] = power_up_r;
            rd_val[msds_pkg::TXRES_BIT] = tx_rst_done_r;
         end
         msds_pkg::CC2_OFF:    rd_val[msds_pkg::RAC_BIT] = rx_active_r;
         msds_pkg::IMR_OFF:    rd_val[1:0] = imr_r;
         msds_pkg::QBASE_OFF:  rd_val = qbase_r;
         msds_pkg::RXBASE_OFF: rd_val = rxbase_r;
         msds_pkg::RXTHR_OFF:  rd_val[4:0] = rx_thr_r;
         msds_pkg::TXD_OFF:    rd_val = '0;
         default:              rd_ok = 1'b0;
      endcase
   end

   always_comb begin
      aw_hold_nxt = aw_hold_r;   waddr_nxt = waddr_r;   w_hold_nxt = w_hold_r;
      wdata_nxt = wdata_r;       bvalid_nxt = bvalid_r; bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;     rdata_nxt = rdata_r;   rresp_nxt = rresp_r;
      ar_pend_nxt = ar_pend_r;   qinit_nxt = qinit_r;   rxd_en_nxt = rxd_en_r;
      txd_en_nxt = txd_en_r;     mode_nxt = mode_r;     power_up_nxt = power_up_r;
      tx_rst_done_nxt = tx_rst_done_r;                  rx_active_nxt = rx_active_r;
      imr_nxt = imr_r;           qbase_nxt = qbase_r;   rxbase_nxt = rxbase_r;
      rx_thr_nxt = rx_thr_r;     cnt_nxt = cnt_r;       stat_nxt = stat_r;
      evptr_nxt = evptr_r;       rxptr_nxt = rxptr_r;   ctl_nxt = ctl_r;
      mreq_nxt = mreq_r;         stat_set = '0;
      rx_pend_nxt = rx_pend_r;   tx_pend_nxt = tx_pend_r;
      rxf_out_ready = 1'b0;
      mreq_valid_nxt = mreq_valid_r && !mem_wr_ready;
      wr_ok = 1'b1;
      wr_go = aw_hold_r && w_hold_r && !bvalid_r &&
              (waddr_r != msds_pkg::TXD_OFF || txf_in_ready);
      if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_nxt = 1'b1;
         waddr_nxt   = {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_hold_nxt = 1'b1;
         wdata_nxt  = s_axi_wdata;
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (wr_go) begin
         aw_hold_nxt = 1'b0;
         w_hold_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         case (waddr_r)
            msds_pkg::GCMD_OFF: begin
               // a request while one is in flight is dropped
               if (wdata_r[msds_pkg::AR_BIT] && !ar_pend_r &&
                   ctl_r == msds_pkg::CTL_IDLE) begin
                  ar_pend_nxt = 1'b1;
                  qinit_nxt   = wdata_r[msds_pkg::QINIT_BIT];
                  rxd_en_nxt  = wdata_r[msds_pkg::RXDMA_BIT];
                  txd_en_nxt  = wdata_r[msds_pkg::TXDMA_BIT];
               end
            end
            msds_pkg::GSTAT_OFF:  stat_nxt = stat_r & ~wdata_r[3:0];
            msds_pkg::GLOBAL_MODE_REG_OFF:  mode_nxt = wdata_r[2:0];
            msds_pkg::CC0_OFF: begin
               power_up_nxt    = wdata_r[msds_pkg::PU_BIT];
               tx_rst_done_nxt = wdata_r[msds_pkg::PU_BIT] &&
                                 (tx_rst_done_r || wdata_r[msds_pkg::TXRES_BIT]);
            end
            msds_pkg::CC2_OFF:    rx_active_nxt = wdata_r[msds_pkg::RAC_BIT];
            msds_pkg::IMR_OFF:    imr_nxt = wdata_r[1:0];
            msds_pkg::QBASE_OFF:  qbase_nxt = wdata_r;
            msds_pkg::RXBASE_OFF: rxbase_nxt = wdata_r;
            msds_pkg::RXTHR_OFF:  rx_thr_nxt = wdata_r[4:0];
            msds_pkg::TXD_OFF:    wr_ok = 1'b1;
            default:              wr_ok = 1'b0;
         endcase
         bresp_nxt = wr_ok ? msds_pkg::RESP_OKAY : msds_pkg::RESP_SLVERR;
      end
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         rdata_nxt  = rd_val;
         rresp_nxt  = rd_ok ? msds_pkg::RESP_OKAY : msds_pkg::RESP_SLVERR;
      end

      case (ctl_r)
         msds_pkg::CTL_IDLE: begin
            if (ar_pend_r) begin
               ar_pend_nxt = 1'b0;
               cnt_nxt     = '0;
               ctl_nxt     = qinit_r ? msds_pkg::CTL_QINIT : msds_pkg::CTL_DONE;
            end else if (mem_free && rx_pend_r) begin
               mreq_valid_nxt = 1'b1;
               mreq_nxt = '{qbase_r + msds_pkg::EVQ_OFF + 32'({evptr_r, 2'b00}),
                            msds_pkg::VEC_RX};
               evptr_nxt = evptr_r + 2'h1;
               rx_pend_nxt = 1'b0;
               stat_set[msds_pkg::RXI_BIT] = 1'b1;
            end else if (mem_free && tx_pend_r) begin
               mreq_valid_nxt = 1'b1;
               mreq_nxt = '{qbase_r + msds_pkg::EVQ_OFF + 32'({evptr_r, 2'b00}),
                            msds_pkg::VEC_TX};
               evptr_nxt = evptr_r + 2'h1;
               tx_pend_nxt = 1'b0;
               stat_set[msds_pkg::TXI_BIT] = 1'b1;
            end else if (rxd_en_r && rx_thr_r != '0 && rxf_level >= rx_thr_r) begin
               cnt_nxt = rx_thr_r;
               ctl_nxt = msds_pkg::CTL_RXMOVE;
            end
         end
         msds_pkg::CTL_QINIT: begin
            // clear the event ring so stale vectors are never mistaken for new ones
            if (mem_free) begin
               mreq_valid_nxt = 1'b1;
               mreq_nxt  = '{qbase_r + msds_pkg::EVQ_OFF + 32'({cnt_r, 2'b00}), 32'h0};
               cnt_nxt   = cnt_r + 5'h01;
               evptr_nxt = '0;
               if (cnt_r == 5'(msds_pkg::EVQ_LEN - 1)) begin
                  ctl_nxt = msds_pkg::CTL_DONE;
               end
            end
         end
         msds_pkg::CTL_DONE: begin
            if (mem_free) begin
               stat_set[msds_pkg::ACK_BIT] = 1'b1;
               if (mode_r[msds_pkg::IRQEN_BIT]) begin
                  stat_set[msds_pkg::CFGI_BIT] = 1'b1;
                  ctl_nxt = msds_pkg::CTL_CFGVEC;
               end else begin
                  ctl_nxt = msds_pkg::CTL_IDLE;
               end
            end
         end
         msds_pkg::CTL_CFGVEC: begin
            if (mem_free) begin
               mreq_valid_nxt = 1'b1;
               mreq_nxt = '{qbase_r, msds_pkg::VEC_CFG};
               ctl_nxt  = msds_pkg::CTL_IDLE;
            end
         end
         msds_pkg::CTL_RXMOVE: begin
            rxf_out_ready = mem_free;
            if (mem_free && rxf_out_valid) begin
               mreq_valid_nxt = 1'b1;
               mreq_nxt  = '{rxbase_r + 32'({rxptr_r, 2'b00}), rxf_out_data};
               rxptr_nxt = rxptr_r + 8'h01;
               cnt_nxt   = cnt_r - 5'h01;
               if (cnt_r == 5'h01) begin
                  ctl_nxt = msds_pkg::CTL_IDLE;
               end
            end
         end
         default: ctl_nxt = msds_pkg::CTL_IDLE;
      endcase
      // events raised in a clearing cycle survive: set is applied last
      stat_nxt    = stat_nxt | stat_set;
      rx_pend_nxt = rx_pend_nxt | (chan_rx_event && power_up_r && !imr_r[0]);
      tx_pend_nxt = tx_pend_nxt | (chan_tx_event && power_up_r && !imr_r[1]);
      irq_nxt     = mode_nxt[msds_pkg::IRQEN_BIT] && (stat_nxt != '0);
      port_nxt.local_bus_en   = 1'b1;
      port_nxt.gp_port_en     = mode_r[1:0] != msds_pkg::PCFG_LBI;
      port_nxt.sync_serial_en = mode_r[1:0] == msds_pkg::PCFG_SSC;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         aw_hold_r <= 1'b0;  w_hold_r <= 1'b0;   waddr_r <= '0;    wdata_r <= '0;
         bvalid_r <= 1'b0;   bresp_r <= '0;      rvalid_r <= 1'b0; rdata_r <= '0;
         rresp_r <= '0;      ar_pend_r <= 1'b0;  qinit_r <= 1'b0;  rxd_en_r <= 1'b0;
         txd_en_r <= 1'b0;   mode_r <= msds_pkg::MODE_RST;         power_up_r <= 1'b0;
         tx_rst_done_r <= 1'b0;                  rx_active_r <= 1'b0;
         imr_r <= msds_pkg::IMR_RST;             qbase_r <= msds_pkg::ADDR_RST;
         rxbase_r <= msds_pkg::ADDR_RST;         rx_thr_r <= msds_pkg::THR_RST;
         cnt_r <= '0;        stat_r <= '0;       rx_pend_r <= 1'b0; tx_pend_r <= 1'b0;
         evptr_r <= '0;      rxptr_r <= '0;      mreq_valid_r <= 1'b0; mreq_r <= '0;
         irq_r <= 1'b0;      port_r <= 3'h4;     ctl_r <= msds_pkg::CTL_IDLE;
      end else begin
         aw_hold_r <= aw_hold_nxt;  w_hold_r <= w_hold_nxt;  waddr_r <= waddr_nxt;
         wdata_r <= wdata_nxt;      bvalid_r <= bvalid_nxt;  bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;    rdata_r <= rdata_nxt;    rresp_r <= rresp_nxt;
         ar_pend_r <= ar_pend_nxt;  qinit_r <= qinit_nxt;    rxd_en_r <= rxd_en_nxt;
         txd_en_r <= txd_en_nxt;    mode_r <= mode_nxt;      power_up_r <= power_up_nxt;
         tx_rst_done_r <= tx_rst_done_nxt;                   rx_active_r <= rx_active_nxt;
         imr_r <= imr_nxt;          qbase_r <= qbase_nxt;    rxbase_r <= rxbase_nxt;
         rx_thr_r <= rx_thr_nxt;    cnt_r <= cnt_nxt;        stat_r <= stat_nxt;
         rx_pend_r <= rx_pend_nxt;  tx_pend_r <= tx_pend_nxt; evptr_r <= evptr_nxt;
         rxptr_r <= rxptr_nxt;      mreq_valid_r <= mreq_valid_nxt; mreq_r <= mreq_nxt;
         irq_r <= irq_nxt;          port_r <= port_nxt;      ctl_r <= ctl_nxt;
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   chk_ack_sticky: assert property (
      stat_r[msds_pkg::ACK_BIT] && !(wr_go && waddr_r == msds_pkg::GSTAT_OFF &&
      wdata_r[msds_pkg::ACK_BIT]) |=> stat_r[msds_pkg::ACK_BIT])
      else $error("acknowledge flag dropped without a clear");
   chk_busy_refuse: assert property (
      ctl_r != msds_pkg::CTL_IDLE && !ar_pend_r |=> !ar_pend_r)
      else $error("action request taken while busy");
   chk_req_init: assert property (
      ar_pend_r && qinit_r && ctl_r == msds_pkg::CTL_IDLE |=>
      ctl_r == msds_pkg::CTL_QINIT ##[1:1000] stat_r[msds_pkg::ACK_BIT])
      else $error("queue setup did not end in acknowledge");
   chk_irq_raise: assert property (
      $rose(stat_r[msds_pkg::CFGI_BIT]) |-> irq_out ##[0:1000]
      (mem_wr_valid && mem_wr.data == msds_pkg::VEC_CFG && mem_wr.addr == qbase_r))
      else $error("config vector or interrupt missing");
   chk_tx_gate: assert property (
      ser_tx_valid |-> power_up_r && tx_rst_done_r && txd_en_r)
      else $error("transmit data offered to a channel not ready");
   // a new word may follow an accepted one, so only a refused offer must hold
   chk_tx_hold: assert property (
      ser_tx_valid && !ser_tx_ready |=> $stable(ser_tx_data) && (ser_tx_valid || !tx_on))
      else $error("transmit word changed before acceptance");
   chk_rx_gate: assert property (
      ser_rx_valid && ser_rx_ready |-> rx_active_r)
      else $error("receive data taken while receiver inactive");
   chk_rx_move: assert property (
      ctl_r == msds_pkg::CTL_IDLE ##1 ctl_r == msds_pkg::CTL_RXMOVE |->
      $past(rxf_level) >= $past(rx_thr_r) && $past(rx_thr_r) != 5'h00)
      else $error("receive move started below threshold");
   chk_event_fwd: assert property (
      $rose(tx_pend_r) |-> ##[1:1000] (mem_wr_valid && mem_wr.data == msds_pkg::VEC_TX))
      else $error("transmit event vector not forwarded");
   chk_mem_hold: assert property (
      mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr))
      else $error("memory write changed before acceptance");
endmodule : msds_top

// file: testbench/msds_mem_model.sv
// shared-memory and serial-line sink model on the far side of the dma block
`timescale 1ns/100ps
module msds_mem_model (
   input  wire logic                    ref_clk,
   input  wire logic                    rst,
   input  wire logic                    mem_wr_valid,
   output logic                         mem_wr_ready,
   input  wire msds_pkg::msds_mem_req_s mem_wr,
   input  wire logic                    ser_tx_valid,
   output logic                         ser_tx_ready,
   input  wire logic [31:0]             ser_tx_data
);
   logic [2:0]  stall_r;
   logic [31:0] last_addr, last_data, tx_last;
   int          n_wr, n_tx;
   // fixed stall pattern so the block must hold its offers over slow answers
   assign mem_wr_ready = stall_r[0];
   assign ser_tx_ready = stall_r[1];
   always_ff @(posedge ref_clk) begin
      stall_r <= rst ? 3'h0 : stall_r + 3'h1;
      if (mem_wr_valid && mem_wr_ready) begin
         n_wr      <= n_wr + 1;
         last_addr <= mem_wr.addr;
         last_data <= mem_wr.data;
      end
      if (ser_tx_valid && ser_tx_ready) begin
         n_tx    <= n_tx + 1;
         tx_last <= ser_tx_data;
      end
   end
endmodule : msds_mem_model

// file: testbench/msds_bench.sv
// self-checking bench for the serial dma start-up block
`timescale 1ns/100ps
module msds_bench;
   logic ref_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, mem_wr_valid;
   logic mem_wr_ready, ser_tx_valid, ser_tx_ready, ser_rx_valid, ser_rx_ready, irq_out;
   logic chan_rx_event, chan_tx_event;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, ser_tx_data, ser_rx_data, rd_v;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp_v;
   msds_pkg::msds_mem_req_s mem_wr;
   msds_pkg::msds_mfp_s     port_sel;
   int          errors, n_tests, cyc;
   msds_top u_dut (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .mem_wr_valid, .mem_wr_ready, .mem_wr, .ser_tx_valid, .ser_tx_ready,
      .ser_tx_data, .ser_rx_valid, .ser_rx_ready, .ser_rx_data, .chan_rx_event,
      .chan_tx_event, .irq_out, .port_sel);
   msds_mem_model u_mem (.ref_clk, .rst, .mem_wr_valid, .mem_wr_ready, .mem_wr,
      .ser_tx_valid, .ser_tx_ready, .ser_tx_data);
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task results;
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   // handshakes are sampled on the falling edge, where they are settled, and acted on at the rise
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(negedge ref_clk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         @(posedge ref_clk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end while (!b);
   endtask : wr
   task rd(input logic [7:0] a);
      logic ar, r;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(negedge ref_clk);
         ar = s_axi_arvalid && s_axi_arready;
         r = s_axi_rvalid;
         rd_v = s_axi_rdata;
         resp_v = s_axi_rresp;
         @(posedge ref_clk);
         if (ar) s_axi_arvalid <= 1'b0;
      end while (!r);
   endtask : rd
   task pause_for(input int nw, input int nt);
      for (int i = 0; i < 300 && (u_mem.n_wr < nw || u_mem.n_tx < nt); i++) @(posedge ref_clk);
   endtask : pause_for
   task ev(input logic rx);
      chan_rx_event <= rx;
      chan_tx_event <= !rx;
      @(posedge ref_clk);
      chan_rx_event <= 1'b0;
      chan_tx_event <= 1'b0;
   endtask : ev
   task rxw(input logic [31:0] d);
      ser_rx_data <= d;
      ser_rx_valid <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (!ser_rx_ready);
   endtask : rxw
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         results();
      end
   end
   initial begin
      {rst, s_axi_bready, s_axi_rready} = 3'h7;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, chan_rx_event, chan_tx_event} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ser_rx_data, ser_rx_valid} = 81'h0;
      s_axi_wstrb = 4'hF;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rd(8'h04); chk(rd_v, 32'h0);
      rd(8'h14); chk(rd_v, 32'h3);
      rd(8'h3C); chk({30'h0, resp_v}, {30'h0, msds_pkg::RESP_SLVERR});
      wr(8'h1C, 32'h100); wr(8'h20, 32'h4);
      // port select follows the mode register one cycle later
      wr(8'h08, 32'h6); @(posedge ref_clk); chk({29'h0, port_sel}, 32'h7);
      wr(8'h00, 32'h3); pause_for(5, 0);
      rd(8'h04); chk(rd_v & 32'h1F, 32'h3);
      chk(u_mem.last_data, msds_pkg::VEC_CFG);
      chk(u_mem.last_addr, 32'h0);
      chk({31'h0, irq_out}, 32'h1);
      wr(8'h04, 32'h3); rd(8'h04); chk(rd_v & 32'h1F, 32'h0);
      // second request lands while the first is still building queues and must be dropped
      wr(8'h00, 32'h3); wr(8'h00, 32'h3); pause_for(11, 0);
      chk(u_mem.n_wr, 32'hA);
      wr(8'h04, 32'h3); wr(8'h0C, 32'h1); wr(8'h0C, 32'h3); wr(8'h10, 32'h0);
      // direction enables are taken only together with the action bit
      wr(8'h00, 32'hD);
      wr(8'h24, 32'hA5A5_0001); wr(8'h24, 32'h5A5A_0002); pause_for(11, 2);
      chk(u_mem.n_tx, 32'h2); chk(u_mem.tx_last, 32'h5A5A_0002);
      wr(8'h14, 32'h0); ev(1'b0); pause_for(12, 2);
      chk(u_mem.last_addr, 32'h40); chk(u_mem.last_data, msds_pkg::VEC_TX);
      ev(1'b1); pause_for(13, 2);
      chk(u_mem.last_addr, 32'h44); chk(u_mem.last_data, msds_pkg::VEC_RX);
      wr(8'h10, 32'h1);
      for (int i = 0; i < 8; i++) rxw(32'h100 + i);
      ser_rx_valid <= 1'b0;
      pause_for(21, 2);
      chk(u_mem.n_wr, 32'h15); chk(u_mem.last_addr, 32'h11C);
      chk(u_mem.last_data, 32'h107);
      results();
   end
endmodule : msds_bench
